// >>> design/step_cal_consts.vh
// constants for the step sequencer and calibration menu controller
// assumes a single 100 MHz clock and one-cycle key and trigger pulses
// How it works
// [RL1] menu then six item presses opens prompt
// [RL2] digits 1,2,3,4 then enter unlocks; clear leaves
// [RL3] calibration only in standby or power state
// [RL4] entry selects trim 1, shows voltage/value/index
// [RL5] trims: vgain, voffset, igain, ioffset, refgain
// [RL6] item from trim 1 selects trim 2
// [RL7] trims 3,4 show current and value swapped
// [RL8] trim 5 shows voltage, value, index 5
// [RL9] up/down adjust, enter stores, clear discards
// [RL10] item after 5 shows revision, then default
// [RL11] enter at default prompt restores factory trims
// [RL12] enter at exit prompt leaves the menu
// [RL13] hold 100 entries of five step parameters
// [RL14] panel edits 0..9, serial writes 0..99
// [RL15] index 10..99 shows extended indicator
// [RL16] set points default zero, clamped to rating
// [RL17] trips default 110 percent, clamped there
// [RL18] arm first, then start begins program
// [RL19] advance on period expiry or start event
// [RL20] period 0 standby, 9999 hold, 9998 jump 0
// [RL21] stop ends program; start resumes same step
// [RL22] memory key select applies entry immediately
// [RL23] clear 5 s resets entry, 10 s all
// [RL24] keys need internal, inputs external control
// [RL25] periods counted in prescaled ticks
// [RL26] advance past 99 wraps to 0
`ifndef STEP_CAL_CONSTS_VH
`define STEP_CAL_CONSTS_VH
`define CLK_HZ          100000000
`define HOLD_ENTRY_S    5
`define HOLD_ALL_S      10
`define HOLD_ENTRY_CYC  (`HOLD_ENTRY_S * `CLK_HZ)
`define HOLD_ALL_CYC    (`HOLD_ALL_S * `CLK_HZ)
`define ITEM_CAL_COUNT  3'h6
`define NUM_STEPS       7'h64
`define PANEL_MAX_STEP  7'h09
`define EXT_MIN_STEP    7'h0a
`define PER_STANDBY     14'h0000
`define PER_JUMP0       14'h270e
`define PER_HOLD        14'h270f
`define TRIM_FACTORY    8'h80
`define V_RATED         16'h2710
`define I_RATED         16'h03e8
`define TRIP_PCT        16'h006e
`define PCT_DIV         16'h0064
`define PRESCALE_DEF    32'h000186a0
`define FW_REV          16'h0001
// display selector codes
`define SH_BLANK        3'h0
`define SH_VOUT         3'h1
`define SH_IOUT         3'h2
`define SH_TRIM         3'h3
`define SH_CAL          3'h4
`define SH_REV          3'h5
`define SH_DEF          3'h6
`define SH_RET          3'h7
// AXI4-Lite byte offsets
`define A_CTRL          8'h00
`define A_STATUS        8'h04
`define A_KEYS          8'h08
`define A_PRESCALE      8'h0c
`define A_STEP_SEL      8'h10
`define A_STEP_V        8'h14
`define A_STEP_I        8'h18
`define A_STEP_OV       8'h1c
`define A_STEP_OC       8'h20
`define A_STEP_PER      8'h24
`define A_TRIM          8'h28
`define A_OUT_SET       8'h2c
`define A_DISP          8'h30
`endif

// >>> design/step_cal_ctrl.v
// step program sequencer and calibration menu, registers over AXI4-Lite
// assumes key and trigger inputs are synchronous one-cycle pulses
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "step_cal_consts.vh"
module step_cal_ctrl #(
    parameter HOLD_ENTRY = `HOLD_ENTRY_CYC,
    parameter HOLD_ALL   = `HOLD_ALL_CYC
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        ce,
    input  wire        key_menu,
    input  wire        key_item,
    input  wire        key_enter,
    input  wire        key_clear,
    input  wire        key_up,
    input  wire        key_down,
    input  wire        key_digit_vld,
    input  wire [3:0]  key_digit,
    input  wire        key_mem,
    input  wire        key_start,
    input  wire        key_stop,
    input  wire        key_arm,
    input  wire        clear_held,
    input  wire        ext_start,
    input  wire        ext_stop,
    input  wire        ext_arm,
    input  wire        ext_clear,
    input  wire [1:0]  supply_state,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [15:0] v_set_out,
    output reg  [15:0] i_set_out,
    output reg  [15:0] ov_trip_out,
    output reg  [15:0] oc_trip_out,
    output reg         output_on,
    output reg  [2:0]  vdisp_sel,
    output reg  [2:0]  idisp_sel,
    output reg  [6:0]  mem_disp,
    output reg         ext_ind,
    output reg  [39:0] trim_bus
);
    localparam [31:0] OV_FULL = ({16'h0, `V_RATED} * {16'h0, `TRIP_PCT}) / {16'h0, `PCT_DIV};
    localparam [31:0] OC_FULL = ({16'h0, `I_RATED} * {16'h0, `TRIP_PCT}) / {16'h0, `PCT_DIV};
    localparam [15:0] OV_MAX = OV_FULL[15:0], OC_MAX = OC_FULL[15:0];
    localparam [2:0] M_IDLE = 3'h0, M_NAV = 3'h1, M_PROMPT = 3'h2, M_TRIM = 3'h3,
                     M_REV = 3'h4, M_DEF = 3'h5, M_RET = 3'h6;
    // sequencer states
    localparam [1:0] Q_IDLE = 2'h0, Q_ARMED = 2'h1, Q_RUN = 2'h2;
    localparam [1:0] ST_STANDBY = 2'h0, ST_POWER = 2'h1;

    // [RL13] step memory
    reg [15:0] mem_v   [0:99];
    reg [15:0] mem_i   [0:99];
    reg [15:0] mem_ov  [0:99];
    reg [15:0] mem_oc  [0:99];
    reg [13:0] mem_per [0:99];
    reg [7:0]  trim_reg [0:4];
    reg [7:0]  edit_reg;
    reg [2:0]  menu_reg, trim_sel_reg, item_cnt_reg, code_cnt_reg;
    reg [1:0]  seq_reg;
    reg [6:0]  step_reg, sel_reg;
    reg [31:0] pre_cnt_reg, prescale_reg;
    reg [13:0] per_cnt_reg;
    reg        int_en_reg, ext_en_reg, apply_reg, wipe_all_reg;
    reg [31:0] hold_cnt_reg;
    reg [6:0]  wipe_idx_reg;
    reg        wiping_reg, wipe_one_reg;
    reg [7:0]  awaddr_reg, araddr_reg;
    reg [31:0] wdata_reg;
    reg        aw_got, w_got;
    integer    k;

    // [RL24] panel keys gated by internal, rear inputs by external control
    wire start_ev = (key_start & int_en_reg) | (ext_start & ext_en_reg);
    wire stop_ev  = (key_stop & int_en_reg) | (ext_stop & ext_en_reg);
    wire arm_ev   = (key_arm & int_en_reg) | (ext_arm & ext_en_reg);
    wire hold_clr = (clear_held & int_en_reg) | (ext_clear & ext_en_reg);
    wire cal_ok   = (supply_state == ST_STANDBY) | (supply_state == ST_POWER); // [RL3]

    function [15:0] clamp16;
        input [15:0] v;
        input [15:0] lim;
        begin
            clamp16 = (v > lim) ? lim : v;
        end
    endfunction

    function [6:0] next_step;
        input [6:0] s;
        begin
            next_step = (s == `NUM_STEPS - 7'h01) ? 7'h00 : s + 7'h01; // [RL26]
        end
    endfunction

    wire        wr_fire = aw_got & w_got & ~s_axi_bvalid;
    wire [13:0] cur_per = mem_per[step_reg];

    always @(posedge clk) begin
        if (!rst_n) begin
            menu_reg <= M_IDLE; trim_sel_reg <= 3'h0; item_cnt_reg <= 3'h0;
            code_cnt_reg <= 3'h0; edit_reg <= 8'h00; seq_reg <= Q_IDLE;
            step_reg <= 7'h00; sel_reg <= 7'h00; pre_cnt_reg <= 32'h0;
            prescale_reg <= `PRESCALE_DEF; per_cnt_reg <= 14'h0;
            int_en_reg <= 1'b1; ext_en_reg <= 1'b1; apply_reg <= 1'b0;
            hold_cnt_reg <= 32'h0; wiping_reg <= 1'b1; wipe_all_reg <= 1'b1;
            wipe_one_reg <= 1'b0; wipe_idx_reg <= 7'h00; output_on <= 1'b0;
            for (k = 0; k < 5; k = k + 1)
                trim_reg[k] <= `TRIM_FACTORY;
            aw_got <= 1'b0; w_got <= 1'b0; awaddr_reg <= 8'h00; araddr_reg <= 8'h00;
            wdata_reg <= 32'h0; s_axi_awready <= 1'b0; s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0; s_axi_bresp <= 2'h0; s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0; s_axi_rresp <= 2'h0; s_axi_rdata <= 32'h0;
            v_set_out <= 16'h0; i_set_out <= 16'h0; ov_trip_out <= 16'h0;
            oc_trip_out <= 16'h0; vdisp_sel <= `SH_VOUT; idisp_sel <= `SH_IOUT;
            mem_disp <= 7'h00; ext_ind <= 1'b0; trim_bus <= 40'h0;
        end else if (ce) begin
            apply_reg <= 1'b0;
            // calibration menu
            case (menu_reg)
                M_IDLE: begin
                    if (key_menu) begin
                        menu_reg <= M_NAV;
                        item_cnt_reg <= 3'h0;
                    end
                end
                M_NAV: begin
                    if (key_clear)
                        menu_reg <= M_IDLE;
                    else if (key_item) begin
                        if (item_cnt_reg == `ITEM_CAL_COUNT - 3'h1) begin
                            menu_reg <= M_PROMPT; // [RL1]
                            code_cnt_reg <= 3'h0;
                        end else
                            item_cnt_reg <= item_cnt_reg + 3'h1;
                    end
                end
                M_PROMPT: begin
                    if (key_clear)
                        menu_reg <= M_IDLE; // [RL2]
                    else if (key_digit_vld) begin
                        if (code_cnt_reg < 3'h4 && key_digit == {1'b0, code_cnt_reg} + 4'h1)
                            code_cnt_reg <= code_cnt_reg + 3'h1; // [RL2]
                        else
                            code_cnt_reg <= 3'h0;
                    end else if (key_enter) begin
                        if (code_cnt_reg == 3'h4 && cal_ok) begin // [RL2] [RL3]
                            menu_reg <= M_TRIM;
                            trim_sel_reg <= 3'h0; // [RL4]
                            edit_reg <= trim_reg[0];
                        end else
                            code_cnt_reg <= 3'h0;
                    end
                end
                M_TRIM: begin
                    if (!cal_ok)
                        menu_reg <= M_IDLE; // [RL3]
                    else if (key_up)
                        edit_reg <= edit_reg + 8'h01; // [RL9]
                    else if (key_down)
                        edit_reg <= edit_reg - 8'h01; // [RL9]
                    else if (key_enter)
                        trim_reg[trim_sel_reg] <= edit_reg; // [RL9]
                    else if (key_clear)
                        menu_reg <= M_IDLE; // [RL9] unsaved edit dropped
                    else if (key_item) begin
                        if (trim_sel_reg == 3'h4)
                            menu_reg <= M_REV; // [RL10]
                        else begin
                            trim_sel_reg <= trim_sel_reg + 3'h1; // [RL6]
                            edit_reg <= trim_reg[trim_sel_reg + 3'h1];
                        end
                    end
                end
                M_REV: begin
                    if (key_item)
                        menu_reg <= M_DEF; // [RL10]
                    else if (key_clear)
                        menu_reg <= M_IDLE;
                end
                M_DEF: begin
                    if (key_enter && cal_ok) begin
                        for (k = 0; k < 5; k = k + 1)
                            trim_reg[k] <= `TRIM_FACTORY; // [RL11]
                    end else if (key_item)
                        menu_reg <= M_RET;
                    else if (key_clear)
                        menu_reg <= M_IDLE;
                end
                M_RET: begin
                    if (key_enter)
                        menu_reg <= M_IDLE; // [RL12]
                    else if (key_item) begin
                        menu_reg <= M_TRIM;
                        trim_sel_reg <= 3'h0;
                        edit_reg <= trim_reg[0];
                    end
                end
                default: menu_reg <= M_IDLE;
            endcase

            // [RL22] memory key picks a panel entry and applies it
            if (key_mem && menu_reg == M_IDLE) begin
                step_reg <= (step_reg >= `PANEL_MAX_STEP) ? 7'h00 : step_reg + 7'h01; // [RL14]
                apply_reg <= 1'b1;
            end

            // sequencer
            pre_cnt_reg <= (pre_cnt_reg >= prescale_reg - 32'h1) ? 32'h0 : pre_cnt_reg + 32'h1;
            case (seq_reg)
                Q_IDLE: if (arm_ev) seq_reg <= Q_ARMED; // [RL18]
                Q_ARMED: begin
                    if (stop_ev)
                        seq_reg <= Q_IDLE;
                    else if (start_ev) begin // [RL18] [RL21] resume at current step
                        seq_reg <= Q_RUN;
                        per_cnt_reg <= 14'h0;
                        apply_reg <= 1'b1;
                    end
                end
                Q_RUN: begin
                    if (stop_ev) begin
                        seq_reg <= Q_ARMED; // [RL21]
                        output_on <= 1'b0;
                    end else if (cur_per == `PER_STANDBY) begin
                        output_on <= 1'b0; // [RL20]
                        seq_reg <= Q_ARMED;
                    end else if (cur_per == `PER_JUMP0) begin
                        step_reg <= 7'h00; // [RL20]
                        per_cnt_reg <= 14'h0;
                        apply_reg <= 1'b1;
                    end else begin
                        output_on <= 1'b1;
                        if (start_ev || (cur_per != `PER_HOLD && pre_cnt_reg == 32'h0 &&
                                         per_cnt_reg + 14'h1 >= cur_per)) begin // [RL19] [RL20]
                            step_reg <= next_step(step_reg);
                            per_cnt_reg <= 14'h0;
                            apply_reg <= 1'b1;
                        end else if (pre_cnt_reg == 32'h0)
                            per_cnt_reg <= per_cnt_reg + 14'h1; // [RL25]
                    end
                end
                default: seq_reg <= Q_IDLE;
            endcase

            // [RL23] held clear: 5 s wipes the entry, 10 s wipes all
            if (hold_clr && menu_reg == M_IDLE) begin
                if (hold_cnt_reg != 32'hffffffff)
                    hold_cnt_reg <= hold_cnt_reg + 32'h1;
                if (hold_cnt_reg == HOLD_ENTRY - 1)
                    wipe_one_reg <= 1'b1;
                if (hold_cnt_reg == HOLD_ALL - 1) begin
                    wiping_reg <= 1'b1;
                    wipe_all_reg <= 1'b1;
                    wipe_idx_reg <= 7'h00;
                end
            end else
                hold_cnt_reg <= 32'h0;

            if (wipe_one_reg) begin
                wipe_one_reg <= 1'b0;
                mem_v[step_reg] <= 16'h0; mem_i[step_reg] <= 16'h0; // [RL16]
                mem_ov[step_reg] <= OV_MAX; mem_oc[step_reg] <= OC_MAX; // [RL17]
                mem_per[step_reg] <= `PER_HOLD;
                apply_reg <= 1'b1;
            end else if (wiping_reg) begin
                // defaults written one entry per cycle, 100 cycles
                mem_v[wipe_idx_reg] <= 16'h0; mem_i[wipe_idx_reg] <= 16'h0; // [RL16]
                mem_ov[wipe_idx_reg] <= OV_MAX; mem_oc[wipe_idx_reg] <= OC_MAX; // [RL17]
                mem_per[wipe_idx_reg] <= `PER_HOLD;
                if (wipe_idx_reg == `NUM_STEPS - 7'h01) begin
                    wiping_reg <= 1'b0;
                    wipe_all_reg <= 1'b0;
                    apply_reg <= 1'b1;
                end
                wipe_idx_reg <= wipe_idx_reg + 7'h01;
            end else if (wr_fire && s_axi_wstrb != 4'h0) begin
                // [RL14] serial side may write any entry 0..99
                case (awaddr_reg)
                    `A_CTRL: begin
                        int_en_reg <= wdata_reg[0];
                        ext_en_reg <= wdata_reg[1];
                    end
                    `A_PRESCALE: prescale_reg <= (wdata_reg == 32'h0) ? 32'h1 : wdata_reg;
                    `A_STEP_SEL: sel_reg <= (wdata_reg[6:0] >= `NUM_STEPS) ?
                                             `NUM_STEPS - 7'h01 : wdata_reg[6:0];
                    `A_STEP_V: mem_v[sel_reg] <= clamp16(wdata_reg[15:0], `V_RATED); // [RL16]
                    `A_STEP_I: mem_i[sel_reg] <= clamp16(wdata_reg[15:0], `I_RATED); // [RL16]
                    `A_STEP_OV: mem_ov[sel_reg] <= clamp16(wdata_reg[15:0], OV_MAX); // [RL17]
                    `A_STEP_OC: mem_oc[sel_reg] <= clamp16(wdata_reg[15:0], OC_MAX); // [RL17]
                    `A_STEP_PER: mem_per[sel_reg] <= (wdata_reg[13:0] > `PER_HOLD) ?
                                                    `PER_HOLD : wdata_reg[13:0];
                    default: ;
                endcase
            end

            if (apply_reg) begin
                v_set_out <= mem_v[step_reg]; // [RL22]
                i_set_out <= mem_i[step_reg];
                ov_trip_out <= mem_ov[step_reg];
                oc_trip_out <= mem_oc[step_reg];
            end

            // displays
            mem_disp <= (menu_reg == M_TRIM) ? {4'h0, trim_sel_reg} + 7'h01 : step_reg; // [RL4]
            ext_ind <= (menu_reg != M_TRIM) && (step_reg >= `EXT_MIN_STEP); // [RL15]
            case (menu_reg)
                M_PROMPT: begin
                    vdisp_sel <= `SH_CAL; // [RL1]
                    idisp_sel <= `SH_BLANK;
                end
                M_TRIM: begin
                    if (trim_sel_reg == 3'h2 || trim_sel_reg == 3'h3) begin
                        vdisp_sel <= `SH_TRIM; // [RL7]
                        idisp_sel <= `SH_IOUT;
                    end else begin
                        vdisp_sel <= `SH_VOUT; // [RL4] [RL6] [RL8]
                        idisp_sel <= `SH_TRIM;
                    end
                end
                M_REV: begin
                    vdisp_sel <= `SH_BLANK;
                    idisp_sel <= `SH_REV; // [RL10]
                end
                M_DEF: begin
                    vdisp_sel <= `SH_DEF; // [RL10]
                    idisp_sel <= `SH_BLANK;
                end
                M_RET: begin
                    vdisp_sel <= `SH_RET; // [RL12]
                    idisp_sel <= `SH_BLANK;
                end
                default: begin
                    vdisp_sel <= `SH_VOUT;
                    idisp_sel <= `SH_IOUT;
                end
            endcase
            // [RL5] trims 1..5: vgain, voffset, igain, ioffset, refgain
            trim_bus <= {trim_reg[4], trim_reg[3], trim_reg[2], trim_reg[1], trim_reg[0]};

            // AXI4-Lite write: address and data taken in either order
            s_axi_awready <= ~aw_got & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~w_got & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got <= 1'b1;
                wdata_reg <= s_axi_wdata;
            end
            if (wr_fire && !wiping_reg && !wipe_one_reg) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_reg > `A_DISP || awaddr_reg[1:0] != 2'h0) ? 2'h2 : 2'h0;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;

            // AXI4-Lite read
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                case (s_axi_araddr)
                    `A_CTRL: s_axi_rdata <= {30'h0, ext_en_reg, int_en_reg};
                    `A_STATUS: s_axi_rdata <= {16'h0, wiping_reg, output_on, seq_reg,
                                               1'b0, menu_reg, 1'b0, step_reg};
                    `A_KEYS: s_axi_rdata <= {29'h0, code_cnt_reg};
                    `A_PRESCALE: s_axi_rdata <= prescale_reg;
                    `A_STEP_SEL: s_axi_rdata <= {25'h0, sel_reg};
                    `A_STEP_V: s_axi_rdata <= {16'h0, mem_v[sel_reg]};
                    `A_STEP_I: s_axi_rdata <= {16'h0, mem_i[sel_reg]};
                    `A_STEP_OV: s_axi_rdata <= {16'h0, mem_ov[sel_reg]};
                    `A_STEP_OC: s_axi_rdata <= {16'h0, mem_oc[sel_reg]};
                    `A_STEP_PER: s_axi_rdata <= {18'h0, mem_per[sel_reg]};
                    `A_TRIM: s_axi_rdata <= {edit_reg, trim_reg[2], trim_reg[1], trim_reg[0]};
                    `A_OUT_SET: s_axi_rdata <= {ov_trip_out[7:0], `FW_REV, v_set_out[7:0]};
                    `A_DISP: s_axi_rdata <= {21'h0, ext_ind, mem_disp, vdisp_sel};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// >>> testbench/keypad_model.sv
// operator keypad and rear trigger model
// assumes go is high one cycle with code: 0..12 keys, 16+d digit d
`timescale 1ns/1ps
module keypad_model (
    input  wire       clk, go,
    input  wire [4:0] code,
    output wire       key_menu, key_item, key_enter, key_clear, key_up, key_down, key_mem,
    output wire       key_start, key_stop, key_arm, ext_start, ext_stop, ext_arm,
    output reg        key_digit_vld = 1'b0,
    output wire [3:0] key_digit
);
    reg [12:0] pulse = 13'h0;
    // single-cycle presses, so no key is ever seen twice
    always @(posedge clk) begin
        pulse <= go ? 13'h1 << code : 13'h0;
        key_digit_vld <= go && code[4];
    end
    assign {ext_arm, ext_stop, ext_start, key_arm, key_stop, key_start, key_mem, key_down,
        key_up, key_clear, key_enter, key_item, key_menu} = pulse;
    assign key_digit = code[3:0];
endmodule

// >>> testbench/step_cal_monitor.sv
// checker for step_cal_ctrl outputs, bound to its ports
// assumes rst_n is a synchronous active-low reset
`timescale 1ns/1ps
`include "step_cal_consts.vh"
module step_cal_monitor (
    input wire        clk, rst_n, output_on, s_axi_arready, s_axi_rvalid,
    input wire [15:0] v_set_out, i_set_out, ov_trip_out, oc_trip_out,
    input wire [2:0]  vdisp_sel, idisp_sel,
    input wire [6:0]  mem_disp,
    input wire [1:0]  s_axi_rresp,
    input wire [31:0] s_axi_rdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_set_limit: assert property (v_set_out <= 16'h2710 && i_set_out <= 16'h03e8)
        else $error("set point high");
    a_trip_limit: assert property (ov_trip_out <= 16'h2af8 && oc_trip_out <= 16'h044c)
        else $error("trip high");
    a_step_range: assert property (mem_disp <= 7'h63) else $error("bad step");
    a_swap_view: assert property (vdisp_sel == `SH_TRIM |->
        idisp_sel == `SH_IOUT && mem_disp inside {7'h3, 7'h4}) else $error("bad view");
    a_volt_view: assert property (idisp_sel == `SH_TRIM |->
        vdisp_sel == `SH_VOUT && mem_disp inside {7'h1, 7'h2, 7'h5}) else $error("bad view");
    a_read_after: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arready))
        else $error("early read");
    a_refuse_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
        s_axi_rdata == 32'h0) else $error("refused data");
    a_ready_pulse: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("arready held");
    c_running: cover property ($rose(output_on));
    c_cal_prompt: cover property (vdisp_sel == `SH_CAL);
    c_swap: cover property (vdisp_sel == `SH_TRIM);
endmodule

// >>> testbench/tb_top.sv
// bench for the step sequencer and calibration menu
// assumes keypad_model pulses keys; the bench is the AXI4-Lite master
`timescale 1ns/1ps
`include "step_cal_consts.vh"
module tb_top;
    logic clk = 0, rst_n = 0, go = 0, ce = 1, clear_held = 0, ext_clear = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0;
    logic [4:0] code = 0;
    logic [1:0] supply_state = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 0;
    wire key_menu, key_item, key_enter, key_clear, key_up, key_down, key_mem, key_start;
    wire key_stop, key_arm, ext_start, ext_stop, ext_arm, key_digit_vld, output_on, ext_ind;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [3:0] key_digit;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [15:0] v_set_out, i_set_out, ov_trip_out, oc_trip_out;
    wire [2:0] vdisp_sel, idisp_sel;
    wire [6:0] mem_disp;
    wire [39:0] trim_bus;
    int fails = 0, cmp_count = 0, i;
    step_cal_ctrl #(.HOLD_ENTRY(50), .HOLD_ALL(100)) step_cal_ctrl_i (.*);
    keypad_model keypad_model_i (.*);
    always #5 clk = ~clk;
    task chk(input logic ok);
        cmp_count++;
        if (ok !== 1'b1) begin fails++; $display("Error %0t: wrong output", $time); end
    endtask
    task press(input [4:0] c);
        @(posedge clk); code <= c; go <= 1;
        @(posedge clk); go <= 0;
        repeat (4) @(posedge clk);
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge clk); s_axi_awaddr <= a; s_axi_wdata <= d;
        s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        chk(s_axi_bresp === 2'h0);
        s_axi_bready <= 0;
    endtask
    task t_unmapped;
        @(posedge clk); s_axi_araddr <= 8'h40; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do begin @(posedge clk); if (s_axi_arready) s_axi_arvalid <= 0; end while (!s_axi_rvalid);
        chk(s_axi_rresp === 2'h2);
        s_axi_rready <= 0;
    endtask
    task t_cal;
        for (i = 0; i < 7; i++) press(i == 0 ? 5'h0 : 5'h1);
        chk(vdisp_sel === `SH_CAL);
        supply_state <= 2'h2;
        for (i = 1; i < 11; i++) begin
            press(i % 5 == 0 ? 5'h2 : 5'(16 + i % 5));
            if (i == 5) begin
                chk(vdisp_sel === `SH_CAL);
                supply_state <= 2'h0;
            end
        end
        chk(vdisp_sel === `SH_VOUT && idisp_sel === `SH_TRIM && mem_disp === 7'h1);
        press(5'h4); press(5'h2);
        chk(trim_bus[7:0] === 8'h81);
        press(5'h1); press(5'h1);
        chk(vdisp_sel === `SH_TRIM && idisp_sel === `SH_IOUT && mem_disp === 7'h3);
        for (i = 0; i < 3; i++) press(5'h1);
        chk(idisp_sel === `SH_REV);
        press(5'h1);
        chk(vdisp_sel === `SH_DEF);
        press(5'h2);
        chk(trim_bus === {5{8'h80}});
        for (i = 0; i < 8 && vdisp_sel !== `SH_RET; i++) press(5'h1);
        press(5'h2);
        chk(vdisp_sel === `SH_VOUT && idisp_sel === `SH_IOUT);
    endtask
    task t_seq;
        wr(`A_STEP_SEL, 32'h0); wr(`A_STEP_V, 32'h4e20);
        wr(`A_STEP_OV, 32'hffff); wr(`A_STEP_PER, 32'h270f);
        wr(`A_STEP_SEL, 32'h1); wr(`A_STEP_V, 32'h12c); wr(`A_STEP_PER, 32'h0);
        press(5'h6);
        chk(v_set_out === 16'h012c && mem_disp === 7'h1 && ext_ind === 1'b0);
        repeat (9) press(5'h6);
        chk(v_set_out === 16'h2710 && ov_trip_out === 16'h2af8);
        press(5'h7);
        chk(output_on === 1'b0);
        press(5'h9); press(5'h7);
        repeat (30) @(posedge clk);
        chk(output_on === 1'b1 && mem_disp === 7'h0);
        press(5'h8);
        chk(output_on === 1'b0);
        press(5'ha);
        chk(output_on === 1'b1 && mem_disp === 7'h0);
        press(5'ha);
        chk(v_set_out === 16'h012c && output_on === 1'b0);
        wr(`A_CTRL, 32'h1);
        repeat (9) press(5'h6);
        press(5'ha);
        chk(output_on === 1'b0 && v_set_out === 16'h2710);
        clear_held <= 1;
        repeat (60) @(posedge clk);
        clear_held <= 0;
        chk(v_set_out === 16'h0);
    endtask
    task finish_test;
        $display("fails=%0d cmp_count=%0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1;
        repeat (120) @(posedge clk);
        t_unmapped; t_cal; t_seq;
        finish_test;
    end
    // whole run needs well under 3000 cycles
    initial begin #300000; fails++; finish_test; end
endmodule
bind step_cal_ctrl step_cal_monitor step_cal_monitor_i (.*);
